// >>> mhsp_pkg.sv
package mhsp_pkg;
	// Frame geometry
	localparam int FRAME_BITS = 32;
	localparam int DATA_BITS = 24;
	localparam int STATUS_BITS = 8;
	localparam int RW_BIT = 23;
	// Output update delay after serial clock falls, in device clocks
	localparam int SDO_DELAY_CLKS = 4;
	// Clocks from pin fall to registered fall detect (two sync stages, one edge stage)
	localparam int SDO_DETECT_CLKS = 3;
	localparam logic [3:0] STEP_DIV_RESET = 4'hf;
	localparam int FRAME_CNT_W = 6;
endpackage

// >>> mhsp_sync.sv
`timescale 1ns/1ps
module mhsp_sync #(
	parameter int WIDTH = 3
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic [WIDTH-1:0] asyncIn,
	output logic [WIDTH-1:0] syncOut
);
	logic [WIDTH-1:0] stage1_reg;
	logic [WIDTH-1:0] stage2_reg;
	logic [WIDTH-1:0] stage1_next;
	logic [WIDTH-1:0] stage2_next;

	// Idle level of select and clock is high
	always_comb
	begin
		stage1_next = asyncIn;
		stage2_next = stage1_reg;
	end

	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			stage1_reg <= '1;
			stage2_reg <= '1;
		end
		else
		begin
			stage1_reg <= stage1_next;
			stage2_reg <= stage2_next;
		end
	end

	assign syncOut = stage2_reg;
endmodule

// >>> motion_ctrl_host_serial_port.sv
`timescale 1ns/1ps
module motion_ctrl_host_serial_port (
	input wire logic clk,
	input wire logic rst,
	input wire logic host_select_n,
	input wire logic hostSerialClk,
	input wire logic hostSerialIn,
	input wire logic interrupt_flag_n,
	input wire logic [mhsp_pkg::STATUS_BITS-1:0] statusBits,
	input wire logic [mhsp_pkg::DATA_BITS-1:0] readData,
	output logic host_out_irq_shared_pin,
	output logic host_out_irq_shared_pin_oe,
	output logic [mhsp_pkg::FRAME_BITS-1:0] frameBuf,
	output logic frameValid,
	output logic frameIsRead,
	output logic [3:0] step_clock_predivider
);
	localparam int FW = mhsp_pkg::FRAME_BITS;
	localparam logic [mhsp_pkg::FRAME_CNT_W-1:0] FRAME_LEN = mhsp_pkg::FRAME_CNT_W'(FW);
	// Sync and edge detect already spend part of the delay; keeps 8-clock bit periods usable
	localparam logic [2:0] DLY_LAST = 3'(mhsp_pkg::SDO_DELAY_CLKS - mhsp_pkg::SDO_DETECT_CLKS);

	// ************************************************
	// Input synchronisation
	// ************************************************
	logic [2:0] syncPins;
	mhsp_sync #(.WIDTH(3)) u_sync (
		.clk(clk),
		.rst(rst),
		.asyncIn({host_select_n, hostSerialClk, hostSerialIn}),
		.syncOut(syncPins)
	);
	logic selN;
	logic sclk;
	logic sdi;
	assign selN = syncPins[2];
	assign sclk = syncPins[1];
	assign sdi = syncPins[0];

	// ************************************************
	// Port state
	// ************************************************
	typedef enum logic [1:0] {MHSP_IDLE, MHSP_ACTIVE} mhsp_state_t;
	mhsp_state_t state_reg, state_next;
	logic selN_reg, selN_next;
	logic sclk_reg, sclk_next;
	logic [FW-1:0] rxShift_reg, rxShift_next;
	logic [FW-1:0] txShift_reg, txShift_next;
	logic [mhsp_pkg::FRAME_CNT_W-1:0] bitCnt_reg, bitCnt_next;
	logic [2:0] dly_reg, dly_next;
	logic dlyRun_reg, dlyRun_next;
	logic sdo_reg, sdo_next;
	logic [FW-1:0] buf_reg, buf_next;
	logic valid_reg, valid_next;
	logic isRead_reg, isRead_next;
	logic selRise;
	logic selFall;
	logic sclkRise;
	logic sclkFall;

	assign selRise = selN & ~selN_reg;
	assign selFall = ~selN & selN_reg;
	assign sclkRise = sclk & ~sclk_reg;
	assign sclkFall = ~sclk & sclk_reg;

	always_comb
	begin
		state_next = state_reg;
		selN_next = selN;
		sclk_next = sclk;
		rxShift_next = rxShift_reg;
		txShift_next = txShift_reg;
		bitCnt_next = bitCnt_reg;
		dly_next = dly_reg;
		dlyRun_next = dlyRun_reg;
		sdo_next = sdo_reg;
		buf_next = buf_reg;
		valid_next = 1'b0;
		isRead_next = isRead_reg;
		unique case (state_reg)
			MHSP_IDLE:
			begin
				sdo_next = interrupt_flag_n;
				if (selFall)
				begin
					state_next = MHSP_ACTIVE;
					bitCnt_next = '0;
					dlyRun_next = 1'b0;
					txShift_next = {statusBits, readData};
					sdo_next = statusBits[mhsp_pkg::STATUS_BITS-1];
				end
			end
			MHSP_ACTIVE:
			begin
				// sample on rising clock, MSB first
				if (sclkRise)
				begin
					rxShift_next = {rxShift_reg[FW-2:0], sdi};
					if (bitCnt_reg != FRAME_LEN)
						bitCnt_next = bitCnt_reg + 1'b1;
				end
				if (sclkFall)
				begin
					dlyRun_next = 1'b1;
					dly_next = '0;
				end
				else if (dlyRun_reg)
				begin
					if (dly_reg == DLY_LAST)
					begin
						dlyRun_next = 1'b0;
						txShift_next = {txShift_reg[FW-2:0], 1'b0};
						// Bit for the coming rise, MSB at the first fall
						sdo_next = txShift_reg[FW-1];
					end
					else
						dly_next = dly_reg + 1'b1;
				end
				if (selRise)
				begin
					state_next = MHSP_IDLE;
					sdo_next = interrupt_flag_n;
					// commit on select rise, full frames only
					if (bitCnt_reg == FRAME_LEN)
					begin
						buf_next = rxShift_reg;
						valid_next = 1'b1;
						isRead_next = rxShift_reg[mhsp_pkg::RW_BIT];
					end
				end
			end
			default:
				state_next = MHSP_IDLE;
		endcase
	end

	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			state_reg <= MHSP_IDLE;
			selN_reg <= 1'b1;
			sclk_reg <= 1'b1;
			rxShift_reg <= '0;
			txShift_reg <= '0;
			bitCnt_reg <= '0;
			dly_reg <= '0;
			dlyRun_reg <= 1'b0;
			sdo_reg <= 1'b1;
			buf_reg <= '0;
			valid_reg <= 1'b0;
			isRead_reg <= 1'b0;
		end
		else
		begin
			state_reg <= state_next;
			selN_reg <= selN_next;
			sclk_reg <= sclk_next;
			rxShift_reg <= rxShift_next;
			txShift_reg <= txShift_next;
			bitCnt_reg <= bitCnt_next;
			dly_reg <= dly_next;
			dlyRun_reg <= dlyRun_next;
			sdo_reg <= sdo_next;
			buf_reg <= buf_next;
			valid_reg <= valid_next;
			isRead_reg <= isRead_next;
		end
	end

	// ************************************************
	// Predivider and pin drive
	// ************************************************
	logic [3:0] div_reg, div_next;
	logic oe_reg, oe_next;

	always_comb
	begin
		div_next = div_reg;
		oe_next = 1'b1;
	end

	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			div_reg <= mhsp_pkg::STEP_DIV_RESET;
			oe_reg <= 1'b1;
		end
		else
		begin
			div_reg <= div_next;
			oe_reg <= oe_next;
		end
	end

	assign host_out_irq_shared_pin = sdo_reg;
	assign host_out_irq_shared_pin_oe = oe_reg;
	assign frameBuf = buf_reg;
	assign frameValid = valid_reg;
	assign frameIsRead = isRead_reg;
	assign step_clock_predivider = div_reg;
endmodule

// >>> mhsp_chk.sv
`timescale 1ns/1ps
module mhsp_chk (
	input wire logic clk,
	input wire logic rst,
	input wire logic host_select_n,
	input wire logic hostSerialClk,
	input wire logic interrupt_flag_n,
	input wire logic host_out_irq_shared_pin,
	input wire logic host_out_irq_shared_pin_oe,
	input wire logic [31:0] frameBuf,
	input wire logic frameValid,
	input wire logic frameIsRead,
	input wire logic [3:0] step_clock_predivider
);
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	// ****
	// Port checks
	// ****
	AST_OE: assert property (host_out_irq_shared_pin_oe)
		else $error("pin undriven");
	AST_DIV: assert property (step_clock_predivider == 4'hf)
		else $error("predivider wrong");
	AST_RST: assert property (disable iff (1'b0) rst |=> !frameValid && !frameBuf)
		else $error("reset state wrong");
	AST_PULSE: assert property (frameValid |=> !frameValid)
		else $error("valid too long");
	AST_RW: assert property (frameValid |-> frameIsRead == frameBuf[23])
		else $error("rw flag wrong");
	AST_HOLD: assert property ($changed(frameBuf) |-> frameValid)
		else $error("buffer changed alone");
	AST_END: assert property (frameValid |-> $past(host_select_n, 3))
		else $error("commit while selected");
	// Host samples on rise, so the bit must hold a while after each fall
	AST_SDO: assert property ($fell(hostSerialClk) && !host_select_n |=>
		$stable(host_out_irq_shared_pin)[*4])
		else $error("output changed early");
	AST_IRQ: assert property (host_select_n[*8] ##0 $stable(interrupt_flag_n) |->
		host_out_irq_shared_pin == interrupt_flag_n)
		else $error("idle pin not irq");
endmodule
bind motion_ctrl_host_serial_port mhsp_chk u_chk (.*);

// >>> mhsp_host.sv
`timescale 1ns/1ps
module mhsp_host (
	input wire logic clk,
	input wire logic sdo,
	output logic selN,
	output logic sck,
	output logic sdi
);
	// ****
	// Serial master
	// ****
	initial
	begin
		selN = 1'b1;
		sck = 1'b1;
		sdi = 1'b0;
	end
	// Low phase outlasts the device's pin update delay
	task automatic xfer(input logic [31:0] tx, input int n, output logic [31:0] rx);
		rx = '0;
		repeat (4) @(negedge clk);
		selN = 1'b0;
		repeat (4) @(negedge clk);
		for (int i = 31; i > 31 - n; i--)
		begin
			// 160 ns bit: five clocks low, three high
			sck = 1'b0;
			sdi = tx[i];
			repeat (5) @(negedge clk);
			rx = {rx[30:0], sdo};
			sck = 1'b1;
			repeat (3) @(negedge clk);
		end
		repeat (3) @(negedge clk);
		selN = 1'b1;
		sdi = ~sdi;
	endtask
endmodule

// >>> motion_ctrl_host_serial_port_tb_top.sv
`timescale 1ns/1ps
module motion_ctrl_host_serial_port_tb_top;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic irqFlagN = 1'b1;
	logic selN, sck, sdi, pin, oe, fv, isRd;
	logic [7:0] st = 8'h00;
	logic [23:0] rd = 24'h000000;
	logic [31:0] fb, rx;
	logic [3:0] div;
	int fail_count, compares, nv;
	always #10 clk = ~clk;
	always @(posedge clk) if (fv === 1'b1) nv++;
	mhsp_host u_host (.clk(clk), .sdo(pin), .selN(selN), .sck(sck), .sdi(sdi));
	motion_ctrl_host_serial_port u_dut (.clk(clk), .rst(rst), .host_select_n(selN),
		.hostSerialClk(sck), .hostSerialIn(sdi), .interrupt_flag_n(irqFlagN),
		.statusBits(st), .readData(rd), .host_out_irq_shared_pin(pin),
		.host_out_irq_shared_pin_oe(oe), .frameBuf(fb), .frameValid(fv),
		.frameIsRead(isRd), .step_clock_predivider(div));
	// ****
	// Tasks
	// ****
	task automatic cmp(input string n, input logic [31:0] e, input logic [31:0] s);
		compares++;
		if (s !== e)
		begin
			fail_count++;
			$display("ERROR %s exp %h got %h", n, e, s);
		end
	endtask
	task automatic results();
		if (fail_count == 0 && compares > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	task automatic do_reset();
		rst = 1'b1;
		repeat (12) @(negedge clk);
		cmp("buf", 32'h0, fb);
		cmp("div", mhsp_pkg::STEP_DIV_RESET, div);
		cmp("out", 3'h6, {oe, pin, isRd});
		rst = 1'b0;
	endtask
	task automatic t_frame(input logic [31:0] tx, input logic [7:0] s, input logic [23:0] d);
		int n0;
		st = s;
		rd = d;
		n0 = nv;
		u_host.xfer(tx, 32, rx);
		repeat (8) @(negedge clk);
		cmp("ret", {s, d}, rx);
		cmp("buf", tx, fb);
		cmp("rw", tx[23], isRd);
		cmp("cnt", n0 + 1, nv);
	endtask
	// A frame one bit short must leave the buffer alone
	task automatic t_short();
		int n0;
		logic [31:0] b;
		n0 = nv;
		b = fb;
		u_host.xfer(32'hffffffff, 31, rx);
		repeat (8) @(negedge clk);
		cmp("short", b, fb);
		cmp("scnt", n0, nv);
	endtask
	task automatic t_irq();
		for (int i = 0; i < 2; i++)
		begin
			irqFlagN = i[0];
			repeat (3) @(negedge clk);
			cmp("irq", i[0], pin);
		end
	endtask
	initial
	begin
		do_reset();
		t_frame(32'ha53c5a69, 8'h81, 24'h5a0f3c);
		t_frame(32'h1ec30081, 8'h7e, 24'ha5f00f);
		t_short();
		t_irq();
		do_reset();
		t_frame(32'h00800001, 8'h00, 24'hffffff);
		results();
	end
	initial
	begin
		#200us;
		fail_count++;
		results();
	end
endmodule
